// ---- design/clock_select_and_ref_output.sv ----
// Clock source selection, internal postscaler and reference clock output.
`timescale 1ns/1ps
`include "clock_select_consts.svh"
module clock_select_and_ref_output
    import clock_select_pkg::*;
(
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic NRST,
    // Register port.
    input wire logic [11:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Oscillator pins, asynchronous to SYS_CLK.
    input wire osc_pins_t OSC_PINS,
    // Configuration and companion logic on SYS_CLK.
    input wire logic [2:0] PRIMARY_OSC_CONFIG,
    input wire logic TWO_SPEED_EN,
    input wire logic STARTUP_EXPIRED,
    input wire logic TIMER_OSC_ENABLE,
    input wire logic TIMER_DIGITAL_INPUT_OPTION,
    input wire logic SLEEP_REQ,
    input wire logic WAKE_REQ,
    // Clock and power outputs.
    output logic DEVICE_CLK,
    output logic IDLE_MODE,
    output logic SLEEP_MODE,
    // Reference clock pin.
    output logic REF_CLOCK_PIN_O,
    output logic REF_CLOCK_PIN_OE
);
    osc_ctrl_t osc_reg;
    ref_ctrl_t ref_reg;
    logic lfs_reg;
    logic startup_done_reg;
    logic [7:0] rdata_reg;
    logic idle_reg;
    logic sleep_reg;
    logic [4:0] pins_vec;
    logic [4:0] pin_lvl;
    logic [4:0] pin_rise;
    logic [7:0] post_cnt_reg;
    logic int_lvl;
    logic pri_lvl;
    logic [2:0] src_lvl;
    logic [2:0] src_last_reg;
    logic [2:0] src_rise;
    clk_src_t want_src;
    clk_src_t cur_src_reg;
    switch_state_t sw_state_reg;
    logic [1:0] sw_cnt_reg;
    logic dev_clk_reg;
    logic ext_or_xtal;
    logic sleep_keep;
    logic xtal_lvl;
    logic ref_src_lvl;
    logic ref_src_last_reg;
    logic [14:0] ref_cnt_reg;
    logic ref_lvl;
    logic ref_out_reg;
    logic ref_oe_reg;
    logic wr_osc;
    logic wr_ref;
    logic timer_allowed;

    // Pin order: primary, timer, fast, slow, crystal from bit 4 down.
    assign pins_vec = OSC_PINS;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            pin_sync u_sync (
                .clk(SYS_CLK),
                .nrst(NRST),
                .pin(pins_vec[gi]),
                .level(pin_lvl[gi]),
                .rise(pin_rise[gi])
            );
        end
    endgenerate

    assign wr_osc = WR && (ADDR == `OFF_OSC_CTRL);
    assign wr_ref = WR && (ADDR == `OFF_REF_CTRL);
    assign timer_allowed = TIMER_OSC_ENABLE || TIMER_DIGITAL_INPUT_OPTION;

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            osc_reg.idle_on_sleep_select <= `IDLE_RESET;
            osc_reg.internal_freq_select <= `IFS_RESET;
            osc_reg.system_clock_select <= `SEL_RESET;
        end else if (wr_osc) begin
            osc_reg.idle_on_sleep_select <= WDATA[7];
            osc_reg.internal_freq_select <= WDATA[6:4];
            if (WDATA[1:0] != `SEL_TIMER || timer_allowed) begin
                osc_reg.system_clock_select <= WDATA[1:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ref_reg <= '0;
        end else if (wr_ref) begin
            ref_reg <= {WDATA[7], WDATA[5:0]};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            lfs_reg <= `LFS_RESET;
        end else if (WR && (ADDR == `OFF_LF_CTRL)) begin
            lfs_reg <= WDATA[7];
        end
    end

    // Status latches once the start-up timer reports expiry.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            startup_done_reg <= !TWO_SPEED_EN;
        end else if (STARTUP_EXPIRED) begin
            startup_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            rdata_reg <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                `OFF_OSC_CTRL: rdata_reg <= {osc_reg.idle_on_sleep_select, osc_reg.internal_freq_select,
                                             startup_done_reg, `OSC_BIT2_VALUE, osc_reg.system_clock_select};
                `OFF_REF_CTRL: rdata_reg <= {ref_reg.ref_out_enable, 1'b0, ref_reg.ref_out_in_sleep,
                                             ref_reg.ref_source_select, ref_reg.ref_divider};
                `OFF_LF_CTRL: rdata_reg <= {lfs_reg, 7'h00};
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // Sleep entry picks Idle or Sleep; a wake request ends either.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            idle_reg <= 1'b0;
            sleep_reg <= 1'b0;
        end else if (WAKE_REQ) begin
            idle_reg <= 1'b0;
            sleep_reg <= 1'b0;
        end else if (SLEEP_REQ && !idle_reg && !sleep_reg) begin
            idle_reg <= osc_reg.idle_on_sleep_select;
            sleep_reg <= !osc_reg.idle_on_sleep_select;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            post_cnt_reg <= 8'h00;
        end else if (pin_rise[2]) begin
            post_cnt_reg <= post_cnt_reg + 8'h01;
        end
    end

    // Postscaler tap: each step down in the code from 7 to 1 halves the fast oscillator once more.
    always_comb begin
        int_lvl = 1'b0;
        case (osc_reg.internal_freq_select)
            `IFS_8MHZ: int_lvl = pin_lvl[2];
            `IFS_31KHZ: int_lvl = lfs_reg ? post_cnt_reg[7] : pin_lvl[1];
            default: int_lvl = post_cnt_reg[`IFS_DIV_TOP - osc_reg.internal_freq_select];
        endcase
    end

    assign pri_lvl = (PRIMARY_OSC_CONFIG == `PRICFG_INT_A || PRIMARY_OSC_CONFIG == `PRICFG_INT_B)
                     ? int_lvl : pin_lvl[4];
    assign src_lvl = {int_lvl, pin_lvl[3], pri_lvl};
    assign src_rise = src_lvl & ~src_last_reg;

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            src_last_reg <= 3'h0;
        end else begin
            src_last_reg <= src_lvl;
        end
    end

    always_comb begin
        case (osc_reg.system_clock_select)
            `SEL_PRIMARY: want_src = SRC_PRIMARY;
            `SEL_TIMER: want_src = SRC_TIMER;
            default: want_src = SRC_INTERNAL;
        endcase
    end

    // Glitch-free switch: the old source gives two edges, then the new one three, clock held low meanwhile.
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            sw_state_reg <= SW_RUN;
            sw_cnt_reg <= 2'd0;
            cur_src_reg <= SRC_PRIMARY;
        end else begin
            case (sw_state_reg)
                SW_RUN: begin
                    sw_cnt_reg <= 2'd0;
                    if (want_src != cur_src_reg) begin
                        sw_state_reg <= SW_OLD;
                    end
                end
                SW_OLD: begin
                    if (src_rise[cur_src_reg]) begin
                        if (sw_cnt_reg == `SW_OLD_EDGES - 2'd1) begin
                            sw_cnt_reg <= 2'd0;
                            cur_src_reg <= want_src;
                            sw_state_reg <= SW_NEW;
                        end else begin
                            sw_cnt_reg <= sw_cnt_reg + 2'd1;
                        end
                    end
                end
                SW_NEW: begin
                    if (src_rise[cur_src_reg]) begin
                        if (sw_cnt_reg == `SW_NEW_EDGES - 2'd1) begin
                            sw_cnt_reg <= 2'd0;
                            sw_state_reg <= SW_RUN;
                        end else begin
                            sw_cnt_reg <= sw_cnt_reg + 2'd1;
                        end
                    end
                end
                default: begin
                    sw_state_reg <= SW_RUN;
                    sw_cnt_reg <= 2'd0;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            dev_clk_reg <= 1'b0;
        end else begin
            dev_clk_reg <= (sw_state_reg == SW_RUN) && !sleep_reg && src_lvl[cur_src_reg];
        end
    end

    // Reference output path.
    assign ext_or_xtal = (PRIMARY_OSC_CONFIG == `PRICFG_FAST_XTAL) || (PRIMARY_OSC_CONFIG == `PRICFG_EXT_CLK);
    assign sleep_keep = ref_reg.ref_out_in_sleep && ref_reg.ref_source_select && ext_or_xtal;
    assign xtal_lvl = pin_lvl[0] && (!sleep_reg || sleep_keep);
    assign ref_src_lvl = ref_reg.ref_source_select ? xtal_lvl : dev_clk_reg;

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ref_src_last_reg <= 1'b0;
            ref_cnt_reg <= 15'h0000;
        end else begin
            ref_src_last_reg <= ref_src_lvl;
            if (ref_src_lvl && !ref_src_last_reg) begin
                ref_cnt_reg <= ref_cnt_reg + 15'h0001;
            end
        end
    end

    // Counter bits toggle at half duty, so each tap keeps a 50 percent shape.
    assign ref_lvl = (ref_reg.ref_divider == 4'h0) ? ref_src_lvl
                     : ref_cnt_reg[ref_reg.ref_divider - 4'h1];

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ref_out_reg <= 1'b0;
            ref_oe_reg <= 1'b0;
        end else begin
            ref_oe_reg <= ref_reg.ref_out_enable;
            ref_out_reg <= ref_reg.ref_out_enable && (!sleep_reg || sleep_keep) && ref_lvl;
        end
    end

    assign RDATA = rdata_reg;
    assign DEVICE_CLK = dev_clk_reg;
    assign IDLE_MODE = idle_reg;
    assign SLEEP_MODE = sleep_reg;
    assign REF_CLOCK_PIN_O = ref_out_reg;
    assign REF_CLOCK_PIN_OE = ref_oe_reg;

    property p_sel_reset;
        @(posedge SYS_CLK) !NRST |=> osc_reg.system_clock_select == `SEL_RESET && osc_reg.internal_freq_select == 3'h6;
    endproperty
    a_sel_reset: assert property (p_sel_reset) else $error("select fields wrong after reset");

    property p_ifs_reset;
        @(posedge SYS_CLK) !NRST ##1 (NRST && !WR) ##1 (NRST && RD && ADDR == `OFF_OSC_CTRL) |=> RDATA[6:4] == 3'h6;
    endproperty
    a_ifs_reset: assert property (p_ifs_reset) else $error("frequency code not 110 after reset");

    property p_timer_ignored;
        @(posedge SYS_CLK) disable iff (!NRST)
            (wr_osc && WDATA[1:0] == `SEL_TIMER && !timer_allowed) |=> $stable(osc_reg.system_clock_select);
    endproperty
    a_timer_ignored: assert property (p_timer_ignored) else $error("timer select not ignored");

    property p_idle_entry;
        @(posedge SYS_CLK) disable iff (!NRST)
            (SLEEP_REQ && !WAKE_REQ && !idle_reg && !sleep_reg) |=>
            (IDLE_MODE == $past(osc_reg.idle_on_sleep_select)) && (SLEEP_MODE != IDLE_MODE);
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("wrong low-power mode entered");

    property p_ref_off;
        @(posedge SYS_CLK) disable iff (!NRST) !ref_reg.ref_out_enable |=> !REF_CLOCK_PIN_OE && !REF_CLOCK_PIN_O;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("reference pin active while disabled");

    property p_switch_pause;
        @(posedge SYS_CLK) disable iff (!NRST) (sw_state_reg != SW_RUN) |=> !DEVICE_CLK;
    endproperty
    a_switch_pause: assert property (p_switch_pause) else $error("device clock ran during switch");

    property p_sleep_ref;
        @(posedge SYS_CLK) disable iff (!NRST) (sleep_reg && !sleep_keep) |=> !REF_CLOCK_PIN_O;
    endproperty
    a_sleep_ref: assert property (p_sleep_ref) else $error("reference ran in sleep");

    property p_reserved_code;
        @(posedge SYS_CLK) disable iff (!NRST)
            (sw_state_reg == SW_RUN && osc_reg.system_clock_select == `SEL_RESERVED && !wr_osc) |=>
            (cur_src_reg == SRC_INTERNAL || sw_state_reg == SW_OLD);
    endproperty
    a_reserved_code: assert property (p_reserved_code) else $error("reserved code not mapped internal");

    property p_status_reset;
        @(posedge SYS_CLK) (!NRST && TWO_SPEED_EN) |=> !startup_done_reg;
    endproperty
    a_status_reset: assert property (p_status_reset) else $error("start-up status not cleared");

    property p_divider_pass;
        @(posedge SYS_CLK) disable iff (!NRST)
            (ref_reg.ref_divider == 4'h0 && ref_reg.ref_out_enable && !sleep_reg) |=>
            REF_CLOCK_PIN_O == $past(ref_src_lvl);
    endproperty
    a_divider_pass: assert property (p_divider_pass) else $error("divider zero not pass-through");
endmodule : clock_select_and_ref_output

// ---- design/clock_select_consts.svh ----
// Register offsets, field codes, reset values and timing counts for the clock selector.
`ifndef CLOCK_SELECT_CONSTS_SVH
`define CLOCK_SELECT_CONSTS_SVH

`define OFF_REF_CTRL 12'hf3d
`define OFF_OSC_CTRL 12'hfd3
`define OFF_LF_CTRL 12'hf9b

`define SEL_RESET 2'h0
`define SEL_PRIMARY 2'h0
`define SEL_TIMER 2'h1
`define SEL_RESERVED 2'h2
`define SEL_INTERNAL 2'h3
`define IFS_RESET 3'h6
`define IFS_8MHZ 3'h7
`define IFS_31KHZ 3'h0
`define IFS_DIV_TOP 3'h6
`define IDLE_RESET 1'b0
`define LFS_RESET 1'b0
`define OSC_BIT2_VALUE 1'b1

`define PRICFG_INT_A 3'h0
`define PRICFG_INT_B 3'h1
`define PRICFG_FAST_XTAL 3'h4
`define PRICFG_EXT_CLK 3'h6

`define SW_OLD_EDGES 2'd2
`define SW_NEW_EDGES 2'd3

`endif

// ---- design/clock_select_pkg.sv ----
// Types shared by the clock selector files.
package clock_select_pkg;
    typedef enum logic [1:0] {SRC_PRIMARY, SRC_TIMER, SRC_INTERNAL} clk_src_t;
    typedef enum {SW_RUN, SW_OLD, SW_NEW} switch_state_t;
    typedef struct packed {
        logic idle_on_sleep_select;
        logic [2:0] internal_freq_select;
        logic [1:0] system_clock_select;
    } osc_ctrl_t;
    typedef struct packed {
        logic ref_out_enable;
        logic ref_out_in_sleep;
        logic ref_source_select;
        logic [3:0] ref_divider;
    } ref_ctrl_t;
    typedef struct packed {
        logic primary;
        logic timer;
        logic fast;
        logic slow;
        logic crystal;
    } osc_pins_t;
endpackage : clock_select_pkg

// ---- design/pin_sync.sv ----
// Two-stage synchroniser for one oscillator pin with a rising-edge pulse.
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Pin and synchronised view.
    input wire logic pin,
    output logic level,
    output logic rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise = sync_reg & ~last_reg;
endmodule : pin_sync

// ---- testbench/ref_clock_load.sv ----
// Oscillator sources feeding the clock selector and a load counting reference pin edges.
`timescale 1ns/1ps
module ref_clock_load
    import clock_select_pkg::*;
#(
    parameter int PRI = 125,
    parameter int TMR = 500,
    parameter int FST = 100,
    parameter int SLW = 2000,
    parameter int XTL = 150
) (
    // Oscillator pins.
    output osc_pins_t osc_pins,
    // Reference pin.
    input wire logic ref_pin,
    input wire logic ref_oe,
    output int ref_edges
);
    logic p = 1'b0;
    logic t = 1'b0;
    logic f = 1'b0;
    logic s = 1'b0;
    logic c = 1'b0;
    initial ref_edges = 0;
    always #PRI p = ~p;
    always #TMR t = ~t;
    always #FST f = ~f;
    always #SLW s = ~s;
    // The external crystal source keeps running; gating it in Sleep is the device's job.
    always #XTL c = ~c;
    assign osc_pins = '{primary: p, timer: t, fast: f, slow: s, crystal: c};
    always @(posedge ref_pin) begin
        if (ref_oe) begin
            ref_edges++;
        end
    end
endmodule : ref_clock_load

// ---- testbench/test_clock_select_and_ref_output.sv ----
// Self-checking bench for the clock selector and reference clock output.
`timescale 1ns/1ps
module test_clock_select_and_ref_output
    import clock_select_pkg::*;
;
    localparam int PRI = 125;
    localparam int TMR = 500;
    localparam int FST = 100;
    localparam int SLW = 2000;
    localparam int XTL = 150;
    localparam int WIN = 2000;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    osc_pins_t pins;
    logic [2:0] cfg = 3'h4;
    logic two_sp = 1'b1;
    logic expired = 1'b0;
    logic t_en = 1'b0;
    logic t_dig = 1'b0;
    logic slp = 1'b0;
    logic wake = 1'b0;
    logic dev_clk;
    logic idle_m;
    logic sleep_m;
    logic ref_o;
    logic ref_oe;
    int failures = 0;
    int checks_done = 0;
    int dev_n = 0;
    int ref_n;
    logic [7:0] osc_v [7] = '{8'h73, 8'h63, 8'h03, 8'h03, 8'h60, 8'h60, 8'h61};
    logic [7:0] lf_v [7] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    logic [2:0] cfg_v [7] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h0, 3'h4};
    int half_v [7] = '{FST, 2 * FST, SLW, 256 * FST, PRI, 2 * FST, TMR};

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge dev_clk) dev_n++;

    clock_select_and_ref_output clock_select_and_ref_output_i (
        .SYS_CLK(sys_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .OSC_PINS(pins), .PRIMARY_OSC_CONFIG(cfg), .TWO_SPEED_EN(two_sp), .STARTUP_EXPIRED(expired),
        .TIMER_OSC_ENABLE(t_en), .TIMER_DIGITAL_INPUT_OPTION(t_dig), .SLEEP_REQ(slp), .WAKE_REQ(wake),
        .DEVICE_CLK(dev_clk), .IDLE_MODE(idle_m), .SLEEP_MODE(sleep_m),
        .REF_CLOCK_PIN_O(ref_o), .REF_CLOCK_PIN_OE(ref_oe)
    );
    ref_clock_load #(.PRI(PRI), .TMR(TMR), .FST(FST), .SLW(SLW), .XTL(XTL)) ref_clock_load_i (
        .osc_pins(pins), .ref_pin(ref_o), .ref_oe(ref_oe), .ref_edges(ref_n)
    );

    task finish_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Edge counts of asynchronous clocks are only exact to a few edges.
    task near(input int got, input int exp);
        checks_done++;
        if (got < exp - 3 || got > exp + 3) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : near

    function automatic int cnt(input int half);
        return WIN * 25 / (2 * half);
    endfunction : cnt

    task wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_chk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    task do_reset(input logic ts);
        @(posedge sys_clk);
        nrst <= 1'b0;
        two_sp <= ts;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
    endtask : do_reset

    task pulse(input int which);
        @(posedge sys_clk);
        if (which == 0) slp <= 1'b1;
        else wake <= 1'b1;
        @(posedge sys_clk);
        slp <= 1'b0;
        wake <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : pulse

    // A negative expectation skips that count.
    task measure(input int exp_dev, input int exp_ref);
        int d0;
        int r0;
        repeat (300) @(posedge sys_clk);
        d0 = dev_n;
        r0 = ref_n;
        repeat (WIN) @(posedge sys_clk);
        if (exp_dev >= 0) near(dev_n - d0, exp_dev);
        if (exp_ref >= 0) near(ref_n - r0, exp_ref);
    endtask : measure

    task t_reset;
        do_reset(1'b1);
        rd_chk(12'hfd3, 8'h64);
        rd_chk(12'hf3d, 8'h00);
        rd_chk(12'hf9b, 8'h00);
        rd_chk(12'h000, 8'h00);
        do_reset(1'b0);
        rd_chk(12'hfd3, 8'h6c);
        $display("test reset done");
    endtask : t_reset

    task t_regs;
        do_reset(1'b1);
        @(posedge sys_clk);
        expired <= 1'b1;
        @(posedge sys_clk);
        expired <= 1'b0;
        rd_chk(12'hfd3, 8'h6c);
        wr_reg(12'hfd3, 8'h02);
        rd_chk(12'hfd3, 8'h0e);
        wr_reg(12'hfd3, 8'h11);
        rd_chk(12'hfd3, 8'h1e);
        @(posedge sys_clk);
        t_dig <= 1'b1;
        wr_reg(12'hfd3, 8'h11);
        rd_chk(12'hfd3, 8'h1d);
        @(posedge sys_clk);
        t_dig <= 1'b0;
        t_en <= 1'b1;
        wr_reg(12'hfd3, 8'h00);
        wr_reg(12'hfd3, 8'hf1);
        rd_chk(12'hfd3, 8'hfd);
        wr_reg(12'hf9b, 8'hff);
        rd_chk(12'hf9b, 8'h80);
        wr_reg(12'hf3d, 8'hff);
        rd_chk(12'hf3d, 8'hbf);
        wr_reg(12'hf9b, 8'h00);
        wr_reg(12'hfd3, 8'h60);
        $display("test registers done");
    endtask : t_regs

    task t_clock;
        wr_reg(12'hf3d, 8'h80);
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            cfg <= cfg_v[i];
            wr_reg(12'hf9b, lf_v[i]);
            wr_reg(12'hfd3, osc_v[i]);
            if (i == 0) begin
                repeat (2) @(posedge sys_clk);
                #1;
                chk({7'h00, dev_clk}, 8'h00);
            end
            measure(cnt(half_v[i]), cnt(half_v[i]));
        end
        $display("test clock select done");
    endtask : t_clock

    task t_ref;
        @(posedge sys_clk);
        cfg <= 3'h4;
        wr_reg(12'hfd3, 8'h60);
        for (int d = 0; d < 4; d++) begin
            wr_reg(12'hf3d, 8'h90 | 8'(d));
            measure(cnt(PRI), cnt(XTL << d));
        end
        chk({7'h00, ref_oe}, 8'h01);
        wr_reg(12'hf3d, 8'hb0);
        pulse(0);
        chk({6'h00, idle_m, sleep_m}, 8'h01);
        measure(0, cnt(XTL));
        pulse(1);
        wr_reg(12'hf3d, 8'h90);
        pulse(0);
        measure(0, 0);
        pulse(1);
        @(posedge sys_clk);
        cfg <= 3'h0;
        wr_reg(12'hf3d, 8'hb0);
        pulse(0);
        measure(0, 0);
        pulse(1);
        chk({6'h00, idle_m, sleep_m}, 8'h00);
        wr_reg(12'hf3d, 8'h00);
        measure(-1, 0);
        chk({7'h00, ref_oe}, 8'h00);
        $display("test reference done");
    endtask : t_ref

    task t_idle;
        wr_reg(12'hfd3, 8'he0);
        pulse(0);
        chk({6'h00, idle_m, sleep_m}, 8'h02);
        pulse(1);
        chk({6'h00, idle_m, sleep_m}, 8'h00);
        $display("test idle done");
    endtask : t_idle

    initial begin
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_regs();
        t_clock();
        t_ref();
        t_idle();
        finish_test();
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        failures++;
        finish_test();
    end
endmodule : test_clock_select_and_ref_output
